/* File: verilog/pcmf_map.svh */
// Register offsets, field positions, reset values and link timing counts.
`ifndef PCMF_MAP_SVH
`define PCMF_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PCMF_ADDR_CTRL     8'h00
`define PCMF_ADDR_FILL     8'h04
`define PCMF_ADDR_TX       8'h08
`define PCMF_ADDR_RX       8'h0c
`define PCMF_ADDR_STATUS   8'h10

// ----------------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------------
`define PCMF_CTRL_BITS     8
`define PCMF_CTRL_RST      8'h30
`define PCMF_FILL_BITS     3
`define PCMF_FILL_RST      3'h0
`define PCMF_STAT_RXRDY    0

// ----------------------------------------------------------------------------
// Word geometry and frame sync timing
// ----------------------------------------------------------------------------
`define PCMF_WORD_BITS     16
`define PCMF_SAMPLE_BITS   13
`define PCMF_SPARE_BITS    3
`define PCMF_LONG_SYNC     3
`define PCMF_FRAME_BITS    16

`endif

/* File: verilog/pcmf_pkg.sv */
// Types shared by the sample formatter.
`default_nettype none

package pcmf_pkg;

  typedef enum logic [1:0] {
    PCMF_FILL_ZERO = 2'b00,
    PCMF_FILL_ONES = 2'b01,
    PCMF_FILL_SIGN = 2'b10,
    PCMF_FILL_PAT  = 2'b11
  } pcmf_fill_t;

  typedef struct packed {
    pcmf_fill_t  fill;
    logic [1:0]  pos;
    logic        lsb_first;
    logic        long_frame;
    logic        master;
    logic        enable;
  } pcmf_ctrl_t;

endpackage : pcmf_pkg

`default_nettype wire

/* File: verilog/pcmf_formatter.sv */
// Voice sample formatter for the serial audio port, with its register slave.
`timescale 1ns/10ps
`default_nettype none
`include "pcmf_map.svh"

module pcmf_formatter
  import pcmf_pkg::*;
#(
  parameter int FRAME_BITS = `PCMF_FRAME_BITS
)
(
  // System clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  // Register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic      [31:0] reg_rdata_out,
  // Link bit clock
  input  wire logic        link_clk_in,
  output logic             pcm_clk_out,
  output logic             pcm_clk_oe_out,
  // Frame sync pin
  input  wire logic        pcm_sync_in,
  output logic             pcm_sync_out,
  output logic             pcm_sync_oe_out,
  // Serial data pins
  input  wire logic        pcm_data_in,
  output logic             pcm_data_out,
  output logic             pcm_data_oe_out
);

  // One extra counter bit so the bit count can be compared against the full word length.
  localparam int CW = $clog2(FRAME_BITS + 1);

  // --------------------------------------------------------------------------
  // Word packing helpers
  // --------------------------------------------------------------------------
  function automatic logic [15:0] pack_word(input logic [12:0] s, input logic [1:0] pos,
                                            input pcmf_fill_t f, input logic [2:0] pat);
    logic [15:0] w;
    logic [2:0]  fv;
    int          j;
    w = 16'h0000;
    j = 0;
    case (f)
      PCMF_FILL_ZERO: fv = 3'h0;
      PCMF_FILL_ONES: fv = 3'h7;
      PCMF_FILL_SIGN: fv = {3{s[12]}};
      default:        fv = pat;
    endcase
    for (int i = 0; i < `PCMF_WORD_BITS; i++)
    begin
      if (i >= int'(pos) && i < int'(pos) + `PCMF_SAMPLE_BITS)
        w[i] = s[i - int'(pos)];
      else
      begin
        w[i] = fv[j];
        j = j + 1;
      end
    end
    return w;
  endfunction : pack_word

  function automatic logic [12:0] take_sample(input logic [15:0] w, input logic [1:0] pos);
    logic [15:0] sh;
    sh = w >> pos;
    return sh[12:0];
  endfunction : take_sample

  function automatic logic [15:0] spare_mask(input logic [1:0] pos);
    return ~(16'h1fff << pos);
  endfunction : spare_mask

  function automatic logic [3:0] wire_index(input logic [3:0] k, input logic lsb);
    return lsb ? k : 4'hf - k;
  endfunction : wire_index

  // --------------------------------------------------------------------------
  // Register slave
  // --------------------------------------------------------------------------
  pcmf_ctrl_t  ctrl;
  logic [2:0]  fill_pat;
  logic [12:0] tx_hold;
  logic        tx_tog;
  logic [12:0] rx_sample;
  logic        rx_ready;
  logic        rx_tog_s1;
  logic        rx_tog_s2;
  logic        rx_tog_s3;
  logic [12:0] rx_hold_l;
  logic        rx_tog_l_q;

  wire         hit_ctrl   = reg_addr_in == `PCMF_ADDR_CTRL;
  wire         hit_fill   = reg_addr_in == `PCMF_ADDR_FILL;
  wire         hit_tx     = reg_addr_in == `PCMF_ADDR_TX;
  wire         hit_rx     = reg_addr_in == `PCMF_ADDR_RX;
  wire         hit_stat   = reg_addr_in == `PCMF_ADDR_STATUS;
  wire         rx_arrived = rx_tog_s2 ^ rx_tog_s3;
  wire         rx_clear   = reg_read_in && hit_rx;
  logic [31:0] next_rdata;

  always_comb
  begin
    if (hit_ctrl)
      next_rdata = {24'h000000, ctrl};
    else if (hit_fill)
      next_rdata = {29'h00000000, fill_pat};
    else if (hit_tx)
      next_rdata = {19'h00000, tx_hold};
    else if (hit_rx)
      next_rdata = {19'h00000, rx_sample};
    else if (hit_stat)
      next_rdata = {31'h00000000, rx_ready};
    else
      next_rdata = 32'h00000000;
  end

  // A new sample that lands in the same cycle as the clearing read keeps the flag set.
  wire next_rx_ready = rx_arrived ? 1'b1 : (rx_clear ? 1'b0 : rx_ready);

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ctrl          <= pcmf_ctrl_t'(`PCMF_CTRL_RST);
      fill_pat      <= `PCMF_FILL_RST;
      tx_hold       <= 13'h0000;
      tx_tog        <= 1'b0;
      reg_rdata_out <= 32'h00000000;
    end
    else
    begin
      if (reg_write_in && hit_ctrl)
        ctrl <= pcmf_ctrl_t'(reg_wdata_in[7:0]);
      if (reg_write_in && hit_fill)
        fill_pat <= reg_wdata_in[2:0];
      if (reg_write_in && hit_tx)
      begin
        tx_hold <= reg_wdata_in[12:0];
        tx_tog  <= ~tx_tog;
      end
      reg_rdata_out <= reg_read_in ? next_rdata : 32'h00000000;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rx_tog_s1 <= 1'b0;
      rx_tog_s2 <= 1'b0;
      rx_tog_s3 <= 1'b0;
      rx_sample <= 13'h0000;
      rx_ready  <= 1'b0;
    end
    else
    begin
      rx_tog_s1 <= rx_tog_l_q;
      rx_tog_s2 <= rx_tog_s1;
      rx_tog_s3 <= rx_tog_s2;
      if (rx_arrived)
        rx_sample <= rx_hold_l;
      rx_ready  <= next_rx_ready;
    end
  end

  // --------------------------------------------------------------------------
  // Link domain: configuration and transmit sample crossing
  // --------------------------------------------------------------------------
  // Configuration crosses as a level; change it only while the port is disabled.
  pcmf_ctrl_t  cfg_s1;
  pcmf_ctrl_t  cfg;
  logic [2:0]  pat_s1;
  logic [2:0]  pat;
  logic        tx_tog_s1;
  logic        tx_tog_s2;
  logic        tx_tog_s3;
  logic [12:0] tx_sample;

  always_ff @(posedge link_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cfg_s1    <= pcmf_ctrl_t'(`PCMF_CTRL_RST);
      cfg       <= pcmf_ctrl_t'(`PCMF_CTRL_RST);
      pat_s1    <= `PCMF_FILL_RST;
      pat       <= `PCMF_FILL_RST;
      tx_tog_s1 <= 1'b0;
      tx_tog_s2 <= 1'b0;
      tx_tog_s3 <= 1'b0;
      tx_sample <= 13'h0000;
    end
    else
    begin
      cfg_s1    <= ctrl;
      cfg       <= cfg_s1;
      pat_s1    <= fill_pat;
      pat       <= pat_s1;
      tx_tog_s1 <= tx_tog;
      tx_tog_s2 <= tx_tog_s1;
      tx_tog_s3 <= tx_tog_s2;
      if (tx_tog_s2 ^ tx_tog_s3)
        tx_sample <= tx_hold;
    end
  end

  // --------------------------------------------------------------------------
  // Link domain: frame timing
  // --------------------------------------------------------------------------
  logic          sync_fall;
  logic          sync_fall_d;
  logic          rx_bit_neg;
  logic [CW-1:0] bit_cnt;

  // Sync and data are sampled on the falling edge, half a bit after they change.
  always_ff @(negedge link_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      sync_fall   <= 1'b0;
      sync_fall_d <= 1'b0;
      rx_bit_neg  <= 1'b0;
    end
    else
    begin
      sync_fall   <= pcm_sync_in;
      sync_fall_d <= sync_fall;
      rx_bit_neg  <= pcm_data_in;
    end
  end

  wire           slave_en    = cfg.enable && !cfg.master;
  wire           align_short = slave_en && !cfg.long_frame && sync_fall;
  wire           align_long  = slave_en && cfg.long_frame && sync_fall && !sync_fall_d;
  wire           wrap        = bit_cnt == CW'(FRAME_BITS - 1);
  wire [CW-1:0]  next_bit    = align_short ? CW'(0) :
                               align_long  ? CW'(1) :
                               wrap        ? CW'(0) : bit_cnt + CW'(1);
  wire           next_slot   = next_bit < CW'(`PCMF_WORD_BITS);
  wire [15:0]    tx_word     = pack_word(tx_sample, cfg.pos, cfg.fill, pat);
  wire [3:0]     tx_idx      = wire_index(next_bit[3:0], cfg.lsb_first);
  // A long pulse only starts at bit 0, so enabling mid-frame never sends a cut pulse.
  wire           long_sync   = next_bit == CW'(0) ||
                               (pcm_sync_out && next_bit < CW'(`PCMF_LONG_SYNC));
  wire           next_sync   = cfg.long_frame ? long_sync :
                                                next_bit == CW'(FRAME_BITS - 1);

  always_ff @(posedge link_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      bit_cnt         <= CW'(0);
      pcm_data_out    <= 1'b0;
      pcm_data_oe_out <= 1'b0;
      pcm_sync_out    <= 1'b0;
    end
    else
    begin
      bit_cnt         <= next_bit;
      pcm_data_out    <= tx_word[tx_idx];
      pcm_data_oe_out <= cfg.enable && next_slot;
      pcm_sync_out    <= cfg.enable && cfg.master && next_sync;
    end
  end

  // The master forwards its bit clock onto the pin; a slave only listens.
  assign pcm_clk_out     = link_clk_in;
  assign pcm_clk_oe_out  = cfg.enable && cfg.master;
  assign pcm_sync_oe_out = cfg.enable && cfg.master;

  // --------------------------------------------------------------------------
  // Link domain: receive word assembly
  // --------------------------------------------------------------------------
  logic [15:0] rx_word;

  wire        in_slot  = bit_cnt < CW'(`PCMF_WORD_BITS);
  wire [3:0]  rx_idx   = wire_index(bit_cnt[3:0], cfg.lsb_first);
  wire [15:0] rx_full  = (rx_word & ~(16'h0001 << rx_idx)) | (16'(rx_bit_neg) << rx_idx);
  wire        rx_cap   = cfg.enable && bit_cnt == CW'(`PCMF_WORD_BITS - 1);

  always_ff @(posedge link_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rx_word    <= 16'h0000;
      rx_hold_l  <= 13'h0000;
      rx_tog_l_q <= 1'b0;
    end
    else
    begin
      if (in_slot)
        rx_word <= rx_full;
      if (rx_cap)
      begin
        rx_hold_l  <= take_sample(rx_full, cfg.pos);
        rx_tog_l_q <= ~rx_tog_l_q;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  wire [15:0] spares = spare_mask(cfg.pos);

  sequence s_long_pulse;
    pcm_sync_out [*3] ##1 !pcm_sync_out;
  endsequence

  a_rx_sample_field: assert property (@(posedge link_clk_in) disable iff (reset_in)
    rx_cap |=> rx_hold_l == $past(rx_full[cfg.pos +: 13]))
    else $error("received sample not taken from the configured field");

  a_tx_bit_order: assert property (@(posedge link_clk_in) disable iff (reset_in)
    cfg.enable && $stable(cfg) && $stable(tx_sample) |=>
      pcm_data_out == $past(tx_word[cfg.lsb_first ? next_bit[3:0] : 4'hf - next_bit[3:0]]))
    else $error("transmitted bit not in the configured order");

  a_rx_spare_ignored: assert property (@(posedge link_clk_in) disable iff (reset_in)
    rx_cap |-> take_sample(rx_full ^ spares, cfg.pos) == take_sample(rx_full, cfg.pos))
    else $error("spare bits leak into the received sample");

  a_fill_const: assert property (@(posedge link_clk_in) disable iff (reset_in)
    cfg.fill == PCMF_FILL_ONES |-> (tx_word & spares) == spares)
    else $error("spare bits not filled with ones");

  a_fill_sign: assert property (@(posedge link_clk_in) disable iff (reset_in)
    cfg.fill == PCMF_FILL_SIGN |-> (tx_word & spares) == (tx_sample[12] ? spares : 16'h0000))
    else $error("spare bits not filled with the sign");

  a_reset_format: assert property (@(posedge sys_clk_in)
    $past(reset_in) && !reset_in |-> ctrl.pos == 2'h3 && !ctrl.lsb_first)
    else $error("format after reset is not left justified MSB first");

  a_slave_no_drive: assert property (@(posedge link_clk_in) disable iff (reset_in)
    !cfg.master |-> !pcm_sync_oe_out && !pcm_clk_oe_out && !pcm_sync_out)
    else $error("slave drives the clock or the sync");

  a_short_sync_width: assert property (@(posedge link_clk_in) disable iff (reset_in)
    cfg.master && !cfg.long_frame && $stable(cfg) && pcm_sync_out |=> !pcm_sync_out && bit_cnt == CW'(0))
    else $error("short sync not one bit wide before the first bit");

  // Disabling the port may cut a pulse short, so the check stops with it.
  a_long_sync_width: assert property (@(posedge link_clk_in)
    disable iff (reset_in || !cfg.enable)
    cfg.master && cfg.long_frame && $stable(cfg) && $rose(pcm_sync_out) |->
      bit_cnt == CW'(0) ##0 s_long_pulse)
    else $error("long sync not three bits from the first bit");

endmodule : pcmf_formatter

`default_nettype wire

/* File: dv/pcmf_codec_model.sv */
// Behavioural codec that frames, sends and captures slot words.
`timescale 1ns/10ps
`default_nettype none

module pcmf_codec_model
(
  // Link clock and mode
  input  wire logic        link_clk_in,
  input  wire logic        dev_master_in,
  input  wire logic        long_in,
  input  wire logic        lsb_in,
  // Pins
  input  wire logic        sync_pin_in,
  input  wire logic        data_pin_in,
  input  wire logic        data_oe_in,
  input  wire logic [15:0] tx_word_in,
  output logic             sync_out,
  output logic             data_out,
  // Capture
  output logic      [15:0] rx_word_out,
  output int               nwords_out,
  output int               sync_run_out
);
  logic [3:0]  cnt = 4'h0;
  logic [3:0]  idx;
  logic [15:0] cap;
  logic        seen = 1'b0;
  logic        prev = 1'b0;
  logic        lrise = 1'b0;
  int          run = 0;
  wire  [3:0]  nxt = lrise ? 4'h1 : (dev_master_in && !long_in && seen) ? 4'h0 : cnt + 4'h1;

  // A released sync line toggles, so a stale level never looks like a pulse.
  always @(posedge link_clk_in)
  begin
    cnt      <= nxt;
    data_out <= tx_word_in[lsb_in ? nxt : 4'hf - nxt];
    sync_out <= dev_master_in ? nxt[0] : (long_in ? (nxt < 4'h3) : (nxt == 4'hf));
  end

  always @(negedge link_clk_in)
  begin
    lrise = dev_master_in && long_in && sync_pin_in && !prev;
    seen  = sync_pin_in;
    prev  = sync_pin_in;
    idx   = lrise ? 4'h0 : cnt;
    cap[lsb_in ? idx : 4'hf - idx] = data_oe_in ? data_pin_in : 1'bx;
    if (idx == 4'hf)
    begin
      rx_word_out = cap;
      nwords_out++;
    end
    if (sync_pin_in)
      run++;
    else if (run > 0)
    begin
      sync_run_out = run;
      run = 0;
    end
  end
endmodule : pcmf_codec_model

`default_nettype wire

/* File: dv/pcm_sample_formatter_test.sv */
// Self-checking bench for the sample formatter against the codec model.
`timescale 1ns/10ps
`default_nettype none
`include "pcmf_map.svh"

module pcm_sample_formatter_test
  import pcmf_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        clk_o, clk_oe, sync_o, sync_oe, data_o, data_oe, m_sync, m_data;
  logic        m_master = 1'b0;
  logic        m_long = 1'b0;
  logic        m_lsb = 1'b0;
  logic [15:0] m_tx = 16'h0;
  logic [15:0] m_rx;
  int          m_words, m_run;
  int          error_cnt = 0;
  int          n_compared = 0;
  wire         sync_pin = sync_oe ? sync_o : m_sync;

  initial forever #50 sys_clk = ~sys_clk;
  // The link clock starts off phase so the two domains never line up.
  initial
  begin
    #17;
    forever #62.5 link_clk = ~link_clk;
  end

  pcmf_formatter dut
  (
    .sys_clk_in(sys_clk), .reset_in(reset), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata), .link_clk_in(link_clk),
    .pcm_clk_out(clk_o), .pcm_clk_oe_out(clk_oe), .pcm_sync_in(sync_pin),
    .pcm_sync_out(sync_o), .pcm_sync_oe_out(sync_oe), .pcm_data_in(m_data),
    .pcm_data_out(data_o), .pcm_data_oe_out(data_oe)
  );

  pcmf_codec_model codec
  (
    .link_clk_in(link_clk), .dev_master_in(m_master), .long_in(m_long), .lsb_in(m_lsb),
    .sync_pin_in(sync_pin), .data_pin_in(data_o), .data_oe_in(data_oe), .tx_word_in(m_tx),
    .sync_out(m_sync), .data_out(m_data), .rx_word_out(m_rx), .nwords_out(m_words),
    .sync_run_out(m_run)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd

  task automatic wait_words(input int n);
    int t;
    t = m_words + n;
    for (int i = 0; i < 30 * n; i++)
    begin
      if (m_words >= t)
        return;
      @(posedge sys_clk);
    end
    error_cnt++;
    tally_and_finish();
  endtask : wait_words

  function automatic logic [15:0] exp_word(input logic [12:0] s, input logic [1:0] pos,
                                           input pcmf_fill_t f, input logic [2:0] pat);
    logic [15:0] w;
    logic [2:0]  fb;
    int          k;
    fb = (f == PCMF_FILL_ZERO) ? 3'h0 : (f == PCMF_FILL_ONES) ? 3'h7 :
         (f == PCMF_FILL_SIGN) ? {3{s[12]}} : pat;
    w  = 16'(s) << pos;
    k  = 0;
    for (int j = 0; j < 16; j++)
      if (j < pos || j > pos + 12)
      begin
        w[j] = fb[k];
        k++;
      end
    return w;
  endfunction : exp_word

  // Configuration is only changed while disabled, since it crosses as a level.
  task automatic run_format(input logic ms, input logic lg, input logic lsb,
                            input logic [1:0] pos, input pcmf_fill_t f,
                            input logic [2:0] pat, input logic [12:0] s);
    pcmf_ctrl_t  c;
    logic [15:0] rxw;
    logic [31:0] d;
    c = '{fill: f, pos: pos, lsb_first: lsb, long_frame: lg, master: ms, enable: 1'b0};
    rxw = 16'h5a3c ^ {s, 3'h5};
    m_master <= ms;
    m_long   <= lg;
    m_lsb    <= lsb;
    m_tx     <= rxw;
    reg_wr(`PCMF_ADDR_FILL, 32'(pat));
    reg_wr(`PCMF_ADDR_CTRL, 32'(c));
    reg_rd(`PCMF_ADDR_RX, d);
    c.enable = 1'b1;
    reg_wr(`PCMF_ADDR_CTRL, 32'(c));
    reg_wr(`PCMF_ADDR_TX, 32'(s));
    wait_words(4);
    check(m_rx, exp_word(s, pos, f, pat));
    check({clk_oe, sync_oe}, {2{ms}});
    check(clk_o, link_clk);
    if (ms)
      check(m_run, lg ? 3 : 1);
    reg_rd(`PCMF_ADDR_STATUS, d);
    check(d, 32'h1);
    reg_rd(`PCMF_ADDR_RX, d);
    check(d, 32'((rxw >> pos) & 16'h1fff));
    c.enable = 1'b0;
    reg_wr(`PCMF_ADDR_CTRL, 32'(c));
  endtask : run_format

  task automatic t_reset_values();
    logic [31:0] d;
    reg_rd(`PCMF_ADDR_CTRL, d);
    check(d, 32'h30);
    reg_rd(`PCMF_ADDR_FILL, d);
    check(d, 32'h0);
    reg_wr(8'h14, 32'hffff_ffff);
    reg_rd(8'h14, d);
    check(d, 32'h0);
    check({clk_oe, sync_oe, data_oe}, 3'h0);
    run_format(1'b1, 1'b0, 1'b0, 2'h3, PCMF_FILL_ZERO, 3'h0, 13'h1234);
  endtask : t_reset_values

  task automatic t_fill_modes();
    for (int i = 0; i < 4; i++)
      run_format(1'b1, 1'b1, 1'b0, 2'h3, pcmf_fill_t'(i), 3'h5, 13'h1a5a);
  endtask : t_fill_modes

  task automatic t_position_order();
    for (int i = 0; i < 4; i++)
      run_format(1'b1, 1'b0, i[0], i[1:0], PCMF_FILL_SIGN, 3'h2, 13'h0b3c);
  endtask : t_position_order

  task automatic t_slave_modes();
    run_format(1'b0, 1'b0, 1'b0, 2'h3, PCMF_FILL_ONES, 3'h0, 13'h0f0f);
    run_format(1'b0, 1'b1, 1'b1, 2'h1, PCMF_FILL_PAT, 3'h6, 13'h1001);
  endtask : t_slave_modes

  initial
  begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset_values();
    t_fill_modes();
    t_position_order();
    t_slave_modes();
    tally_and_finish();
  end
endmodule : pcm_sample_formatter_test

`default_nettype wire
